/* File: hdl/afr_consts.vh */
// Register map, field positions and reset values of the fault report control
// How it works
// - Report block bit 7 hides overtemp shutdown
// - Report block bit 6 hides digital undervoltage
// - Report block bit 5 hides digital overvoltage
// - Report block bit 4 hides clock fault
// - Report block bit 2 hides power supply range
// - Report block bit 1 hides output offset
// - Report block bit 0 hides overcurrent
// - Hold bit 7 latches current limit error
// - Hold bit 6 latches current limit warning
// - Hold bit 5 latches clock error
// - Hold bit 4 latches overtemp shutdown
// - Hold bit 3 latches overtemp warning
// - Hold register bit 2 hides overtemp warning
// - Hold register bit 1 hides limit warning
// - Hold register bit 0 hides limit error
// - Misc bit 7 latches clock detect status
// - Misc bit 4 enables overtemp self recovery
// - Clear bit 7 write one clears faults
// - Latched flags stay set until cleared
// - Unmasked faults drive the fault output
// - Clock fault tristates outputs, recovers itself
`ifndef AFR_CONSTS_VH
`define AFR_CONSTS_VH

// Byte addresses of the registers
`define AFR_ADDR_REPORT_MASK  8'h74
`define AFR_ADDR_HOLD_MASK    8'h75
`define AFR_ADDR_MISC         8'h76
`define AFR_ADDR_LIMIT        8'h77
`define AFR_ADDR_CLEAR        8'h78
`define AFR_ADDR_STATUS       8'h79

// Reset values
`define AFR_RST_REPORT_MASK   8'h00
`define AFR_RST_HOLD_MASK     8'hf8
`define AFR_RST_MISC          8'h00
`define AFR_RST_LIMIT         8'h00

// Writable bits of the report mask (bit 3 reserved, reads zero)
`define AFR_REPORT_MASK_WR    8'hf7

// Report mask fields
`define AFR_B_OVERTEMP_SHUTDOWN            7
`define AFR_B_DUV             6
`define AFR_B_DOV             5
`define AFR_B_CLK             4
`define AFR_B_PSR             2
`define AFR_B_DC              1
`define AFR_B_OC              0

// Hold and warning mask fields
`define AFR_B_CLE_HOLD        7
`define AFR_B_CLW_HOLD        6
`define AFR_B_CLK_HOLD        5
`define AFR_B_OVERTEMP_SHUTDOWN_HOLD       4
`define AFR_B_OTW_HOLD        3
`define AFR_B_OTW_BLK         2
`define AFR_B_CLW_BLK         1
`define AFR_B_CLE_BLK         0

// Misc and limit control fields
`define AFR_B_DET_HOLD        7
`define AFR_B_AUTO_REC        4
`define AFR_B_LIM_FUNC        2
`define AFR_B_LIM_WARN        1
`define AFR_B_LIM_ERR         0

// Clear register field
`define AFR_B_CLEAR           7

// Status register fields (event index order)
`define AFR_S_OC              0
`define AFR_S_DC              1
`define AFR_S_PSR             2
`define AFR_S_CLK             3
`define AFR_S_DOV             4
`define AFR_S_DUV             5
`define AFR_S_OVERTEMP_SHUTDOWN            6
`define AFR_S_OTW             7
`define AFR_S_CLW             8
`define AFR_S_CLE             9
`define AFR_NUM_EV            10

`endif

/* File: hdl/afr_fault_report.v */
// Fault report control with an Avalon-MM register slave
`include "afr_consts.vh"

module afr_fault_report (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        rst_b,
   // Avalon-MM slave
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   // Raw detector levels from the analog side
   input  wire        det_overcurrent,
   input  wire        det_output_offset,
   input  wire        det_power_supply_range,
   input  wire        det_clock_error,
   input  wire        det_digital_supply_over,
   input  wire        det_digital_supply_under,
   input  wire        det_overtemp_shutdown,
   input  wire        det_overtemp_warning,
   input  wire        det_current_limit_warning,
   input  wire        det_current_limit_error,
   input  wire        det_clock_detect,
   // Outputs to pin and power stage
   output reg         fault_report_b,
   output reg         power_stage_hiz,
   output reg         clock_detect_status,
   output reg         overtemp_self_recovery_on,
   output reg         current_limit_function_on,
   output reg         current_limit_warning_on,
   output reg         current_limit_error_on,
   output reg         analog_fault_clear
);

   localparam NEV = `AFR_NUM_EV;

   // Overview of the data flow
   // Each detector level passes two flip-flops before any logic reads it.
   // The synchronised level sets its flag on every clock edge it is high.
   // A flag whose hold enable is low simply follows the detector.
   // A flag whose hold enable is high stays set until a clear write.
   // Supply, offset and overcurrent flags have no enable and always hold.
   // When a clear write meets a live detector the set wins, so a fault
   // that is still present can never be lost by an early clear.
   // The report blocks gate only the fault pin, never the flags, so
   // software can still read a blocked fault in the status register.
   // The fault pin is active low and falls while any shown flag is set.
   // The power stage goes high impedance while the clock error is live;
   // it is not latched, so the stage returns as soon as the clock is back.
   // The clock detect status is either live or held, per the misc bit;
   // a held status is dropped by the same clear write as the flags.
   // The clear bit is never stored; it leaves a one cycle pulse on
   // the analog clear output and reads back as zero.
   // Bus timing: a request is taken on the edge where read or write is
   // high and no answer is pending; waitrequest is low in the next
   // cycle only, with read data registered at the taking edge.
   // A write needs byte lane 0 enabled; other lanes are ignored.
   // Unmapped addresses read zero and ignore writes.
   // Latency from a detector edge to the fault pin is four clock edges.
   // Hazard: a detector pulse shorter than one clock may be missed.

   // Registers
   reg  [7:0]     report_mask_q;
   reg  [7:0]     hold_mask_q;
   reg  [7:0]     misc_q;
   reg  [7:0]     limit_q;
   reg  [NEV-1:0] flags_q;
   reg  [NEV-1:0] sync1_q;
   reg  [NEV-1:0] sync2_q;
   reg            det1_q;
   reg            det2_q;
   reg            det_held_q;
   reg            answered_q;

   // Combinational terms
   wire [NEV-1:0] raw_ev;
   wire [NEV-1:0] hold_en;
   wire [NEV-1:0] blocked;
   wire [NEV-1:0] shown;
   wire           wr_hit;
   wire           clr_hit;
   wire           access;
   wire           wr_report;
   wire           wr_hold;
   wire           wr_misc;
   wire           wr_limit;
   reg  [31:0]    rd_d;

   // Byte 0 write strobe for a given address
   function wr_sel;
      input [7:0] a;
      begin
         wr_sel = avs_write & ~answered_q & avs_byteenable[0] &
                  (avs_address == a);
      end
   endfunction

   assign raw_ev = {det_current_limit_error, det_current_limit_warning,
                    det_overtemp_warning, det_overtemp_shutdown,
                    det_digital_supply_under, det_digital_supply_over,
                    det_clock_error, det_power_supply_range,
                    det_output_offset, det_overcurrent};

   // Per event hold enables; supply, offset and overcurrent always latch
   assign hold_en = {hold_mask_q[`AFR_B_CLE_HOLD],
                     hold_mask_q[`AFR_B_CLW_HOLD],
                     hold_mask_q[`AFR_B_OTW_HOLD],
                     hold_mask_q[`AFR_B_OVERTEMP_SHUTDOWN_HOLD],
                     1'b1, 1'b1,
                     hold_mask_q[`AFR_B_CLK_HOLD],
                     1'b1, 1'b1, 1'b1};

   // Per event report blocks
   assign blocked = {hold_mask_q[`AFR_B_CLE_BLK],
                     hold_mask_q[`AFR_B_CLW_BLK],
                     hold_mask_q[`AFR_B_OTW_BLK],
                     report_mask_q[`AFR_B_OVERTEMP_SHUTDOWN],
                     report_mask_q[`AFR_B_DUV],
                     report_mask_q[`AFR_B_DOV],
                     report_mask_q[`AFR_B_CLK],
                     report_mask_q[`AFR_B_PSR],
                     report_mask_q[`AFR_B_DC],
                     report_mask_q[`AFR_B_OC]};

   assign shown   = flags_q & ~blocked;
   assign access  = (avs_read | avs_write) & ~answered_q;
   assign wr_hit  = avs_write & ~answered_q;
   assign clr_hit = wr_sel(`AFR_ADDR_CLEAR) &
                    avs_writedata[`AFR_B_CLEAR];

   // Write strobes of the control registers
   assign wr_report = wr_sel(`AFR_ADDR_REPORT_MASK);
   assign wr_hold   = wr_sel(`AFR_ADDR_HOLD_MASK);
   assign wr_misc   = wr_sel(`AFR_ADDR_MISC);
   assign wr_limit  = wr_sel(`AFR_ADDR_LIMIT);

   // Fault detector synchronisers
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         sync1_q <= {NEV{1'b0}};
         sync2_q <= {NEV{1'b0}};
      end else begin
         sync1_q <= raw_ev;
         sync2_q <= sync1_q;
      end
   end

   // Clock detect synchroniser
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         det1_q <= 1'b0;
         det2_q <= 1'b0;
      end else begin
         det1_q <= det_clock_detect;
         det2_q <= det1_q;
      end
   end

   // Next value of one flag: a live event sets it, a held flag
   // survives unless a clear is written; set beats clear
   function flag_next;
      input integer i;
      begin
         flag_next = sync2_q[i] | (flags_q[i] & hold_en[i] & ~clr_hit);
      end
   endfunction

   // Overcurrent flag, always held
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         flags_q[`AFR_S_OC] <= 1'b0;
      end else begin
         flags_q[`AFR_S_OC] <= flag_next(`AFR_S_OC);
      end
   end

   // Output offset flag, always held
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         flags_q[`AFR_S_DC] <= 1'b0;
      end else begin
         flags_q[`AFR_S_DC] <= flag_next(`AFR_S_DC);
      end
   end

   // Power supply range flag, always held
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         flags_q[`AFR_S_PSR] <= 1'b0;
      end else begin
         flags_q[`AFR_S_PSR] <= flag_next(`AFR_S_PSR);
      end
   end

   // Clock error flag, held when enabled
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         flags_q[`AFR_S_CLK] <= 1'b0;
      end else begin
         flags_q[`AFR_S_CLK] <= flag_next(`AFR_S_CLK);
      end
   end

   // Digital supply over flag, always held
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         flags_q[`AFR_S_DOV] <= 1'b0;
      end else begin
         flags_q[`AFR_S_DOV] <= flag_next(`AFR_S_DOV);
      end
   end

   // Digital supply under flag, always held
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         flags_q[`AFR_S_DUV] <= 1'b0;
      end else begin
         flags_q[`AFR_S_DUV] <= flag_next(`AFR_S_DUV);
      end
   end

   // Overtemp shutdown flag, held when enabled
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         flags_q[`AFR_S_OVERTEMP_SHUTDOWN] <= 1'b0;
      end else begin
         flags_q[`AFR_S_OVERTEMP_SHUTDOWN] <= flag_next(`AFR_S_OVERTEMP_SHUTDOWN);
      end
   end

   // Overtemp warning flag, held when enabled
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         flags_q[`AFR_S_OTW] <= 1'b0;
      end else begin
         flags_q[`AFR_S_OTW] <= flag_next(`AFR_S_OTW);
      end
   end

   // Current limit warning flag, held when enabled
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         flags_q[`AFR_S_CLW] <= 1'b0;
      end else begin
         flags_q[`AFR_S_CLW] <= flag_next(`AFR_S_CLW);
      end
   end

   // Current limit error flag, held when enabled
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         flags_q[`AFR_S_CLE] <= 1'b0;
      end else begin
         flags_q[`AFR_S_CLE] <= flag_next(`AFR_S_CLE);
      end
   end

   // Clock detect status, held or live
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         det_held_q <= 1'b0;
      end else if (misc_q[`AFR_B_DET_HOLD]) begin
         det_held_q <= det2_q | (det_held_q & ~clr_hit);
      end else begin
         det_held_q <= det2_q;
      end
   end

   // Report mask; the reserved bit stays zero
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         report_mask_q <= `AFR_RST_REPORT_MASK;
      end else if (wr_report) begin
         report_mask_q <= avs_writedata[7:0] & `AFR_REPORT_MASK_WR;
      end
   end

   // Hold enables and warning blocks
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         hold_mask_q <= `AFR_RST_HOLD_MASK;
      end else if (wr_hold) begin
         hold_mask_q <= avs_writedata[7:0];
      end
   end

   // Miscellaneous control
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         misc_q <= `AFR_RST_MISC;
      end else if (wr_misc) begin
         misc_q <= avs_writedata[7:0];
      end
   end

   // Current limit control
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         limit_q <= `AFR_RST_LIMIT;
      end else if (wr_limit) begin
         limit_q <= avs_writedata[7:0];
      end
   end

   // Read multiplexer; unmapped addresses read zero
   always @* begin
      rd_d = 32'h00000000;
      case (avs_address)
         `AFR_ADDR_REPORT_MASK: rd_d[7:0] = report_mask_q;
         `AFR_ADDR_HOLD_MASK:   rd_d[7:0] = hold_mask_q;
         `AFR_ADDR_MISC:        rd_d[7:0] = misc_q;
         `AFR_ADDR_LIMIT:       rd_d[7:0] = limit_q;
         `AFR_ADDR_CLEAR:       rd_d[7:0] = 8'h00;
         `AFR_ADDR_STATUS:      rd_d[NEV-1:0] = flags_q;
         default:               rd_d = 32'h00000000;
      endcase
   end

   // Bus answer: one wait cycle, then waitrequest low for one cycle
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         answered_q      <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         answered_q      <= access;
         avs_waitrequest <= ~access;
      end
   end

   // Read data captured at the taking edge, kept until the next answer
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         avs_readdata <= 32'h00000000;
      end else if (access) begin
         avs_readdata <= rd_d;
      end
   end

   // Fault pin, power stage and clock detect status
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         fault_report_b      <= 1'b1;
         power_stage_hiz     <= 1'b0;
         clock_detect_status <= 1'b0;
      end else begin
         fault_report_b      <= ~(|shown);
         power_stage_hiz     <= sync2_q[`AFR_S_CLK];
         clock_detect_status <= det_held_q;
      end
   end

   // Control copies and clear pulse
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         overtemp_self_recovery_on <= 1'b0;
         current_limit_function_on <= 1'b0;
         current_limit_warning_on  <= 1'b0;
         current_limit_error_on    <= 1'b0;
         analog_fault_clear        <= 1'b0;
      end else begin
         overtemp_self_recovery_on <= misc_q[`AFR_B_AUTO_REC];
         current_limit_function_on <= limit_q[`AFR_B_LIM_FUNC];
         current_limit_warning_on  <= limit_q[`AFR_B_LIM_WARN];
         current_limit_error_on    <= limit_q[`AFR_B_LIM_ERR];
         analog_fault_clear        <= clr_hit;
      end
   end

endmodule

/* File: tb/afr_fault_report_assertions.sv */
// Port-level assertions for the fault report control
module afr_chk (
   // Clock and reset
   input logic        ref_clk,
   input logic        rst_b,
   // Register bus
   input logic [7:0]  avs_address,
   input logic        avs_read,
   input logic        avs_write,
   input logic [31:0] avs_writedata,
   input logic [3:0]  avs_byteenable,
   input logic [31:0] avs_readdata,
   input logic        avs_waitrequest,
   // Detector and outputs
   input logic        det_clock_error,
   input logic        fault_report_b,
   input logic        power_stage_hiz,
   input logic        overtemp_self_recovery_on,
   input logic        current_limit_function_on,
   input logic        current_limit_warning_on,
   input logic        current_limit_error_on,
   input logic        analog_fault_clear
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // Write request taken at this edge
   wire wt = avs_write && avs_waitrequest && avs_byteenable[0];
   // Bus handshake and reset state
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low too long");
   take_answer_a: assert property ((avs_read || avs_write) &&
      avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
   reset_idle_a: assert property ($rose(rst_b) |->
      avs_waitrequest && fault_report_b) else $error("bad reset state");
   // Power stage follows the clock error
   hiz_on_a: assert property (
      det_clock_error [*5] |-> power_stage_hiz) else $error("no hiz");
   hiz_off_a: assert property (
      !det_clock_error [*5] |-> !power_stage_hiz) else $error("stuck hiz");
   // Clear register
   clear_pulse_a: assert property (
      wt && avs_address == 8'h78 && avs_writedata[7] |->
      ##[1:2] analog_fault_clear ##1 !analog_fault_clear)
      else $error("bad clear pulse");
   clear_read_a: assert property (
      avs_read && avs_waitrequest && avs_address == 8'h78 |=>
      avs_readdata[7:0] == 8'h00) else $error("clear readable");
   // Control copies
   limit_copy_a: assert property (
      wt && avs_address == 8'h77 |-> ##[1:2] {current_limit_function_on,
      current_limit_warning_on, current_limit_error_on} ==
      $past(avs_writedata[2:0])) else $error("limit copy wrong");
   recovery_copy_a: assert property (
      wt && avs_address == 8'h76 |-> ##[1:2] overtemp_self_recovery_on ==
      $past(avs_writedata[4])) else $error("recovery copy wrong");
   // Main scenarios
   cover property (power_stage_hiz);
   cover property (analog_fault_clear);
   cover property (wt && avs_address == 8'h77);
endmodule

bind afr_fault_report afr_chk i_chk (.*);

/* File: tb/afr_fault_report_bench.sv */
// Register-level testbench for the fault report control
module afr_fault_report_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, rst_b, avs_read, avs_write, cd, hiz, cds;
   logic        fault_report_b, avs_waitrequest;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0]  avs_byteenable, ctl;
   logic [9:0]  det;
   int          errors, compares;
   int          mbit [10] = '{0, 1, 2, 4, 5, 6, 7, 2, 1, 0};
   int          hold [5] = '{9, 8, 3, 6, 7};

   afr_fault_report i_dut (
      .ref_clk, .rst_b, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .det_overcurrent(det[0]), .det_output_offset(det[1]),
      .det_power_supply_range(det[2]), .det_clock_error(det[3]),
      .det_digital_supply_over(det[4]), .det_digital_supply_under(det[5]),
      .det_overtemp_shutdown(det[6]), .det_overtemp_warning(det[7]),
      .det_current_limit_warning(det[8]), .det_current_limit_error(det[9]),
      .det_clock_detect(cd), .fault_report_b, .power_stage_hiz(hiz),
      .clock_detect_status(cds), .overtemp_self_recovery_on(ctl[3]),
      .current_limit_function_on(ctl[2]), .current_limit_warning_on(ctl[1]),
      .current_limit_error_on(ctl[0]), .analog_fault_clear());

   // 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic end_of_test;
      if (errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   // One bus cycle, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, d);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 20) begin
         errors++;
         end_of_test();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
      bus(1'b0, a, 8'h00);
      chk(n, e, q);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask

   // Sets or lifts the report block of one event
   task automatic blk(input int i, input logic on);
      logic [7:0] m;
      m = on ? 8'h01 << mbit[i] : 8'h00;
      bus(1'b1, i < 7 ? 8'h74 : 8'h75, i < 7 ? m : m | 8'hf8);
   endtask

   // Main sequence
   initial begin
      {rst_b, avs_read, avs_write, cd, det} = '0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      errors = 0;
      compares = 0;
      cyc(2);
      rst_b <= 1'b1;
      rd(8'h74, 32'h00, "mask");
      rd(8'h75, 32'hf8, "hold");
      rd(8'h76, 32'h00, "misc");
      rd(8'h77, 32'h00, "limit");
      rd(8'h80, 32'h00, "unmapped");
      bus(1'b1, 8'h74, 8'hff);
      rd(8'h74, 32'hf7, "mask_rw");
      avs_byteenable <= 4'he;
      bus(1'b1, 8'h74, 8'h00);
      avs_byteenable <= 4'hf;
      rd(8'h74, 32'hf7, "lane_off");
      bus(1'b1, 8'h77, 8'h05);
      bus(1'b1, 8'h76, 8'h10);
      cyc(2);
      chk("ctl", 32'hd, {28'h0, ctl});
      rd(8'h78, 32'h00, "clear_rd");
      // Every event blocked, then reported and held until cleared
      for (int i = 0; i < 10; i++) begin
         blk(i, 1'b1);
         det[i] <= 1'b1;
         cyc(6);
         chk("blocked", 32'h1, {31'h0, fault_report_b});
         rd(8'h79, 32'h1 << i, "flag");
         blk(i, 1'b0);
         cyc(6);
         chk("report", 32'h0, {31'h0, fault_report_b});
         if (i == 3) chk("hiz", 32'h1, {31'h0, hiz});
         det[i] <= 1'b0;
         cyc(6);
         chk("held", 32'h0, {31'h0, fault_report_b});
         chk("hiz_gone", 32'h0, {31'h0, hiz});
         bus(1'b1, 8'h78, 8'h80);
         cyc(2);
         chk("cleared", 32'h1, {31'h0, fault_report_b});
         rd(8'h79, 32'h0, "flag_clr");
      end
      // Optional latches off: the flag follows the detector
      bus(1'b1, 8'h75, 8'h00);
      foreach (hold[j]) begin
         det[hold[j]] <= 1'b1;
         cyc(6);
         rd(8'h79, 32'h1 << hold[j], "live");
         det[hold[j]] <= 1'b0;
         cyc(6);
         rd(8'h79, 32'h0, "live_drop");
      end
      // Clock detect status live, then held
      cd <= 1'b1;
      cyc(6);
      chk("det_live", 32'h1, {31'h0, cds});
      cd <= 1'b0;
      cyc(6);
      chk("det_drop", 32'h0, {31'h0, cds});
      bus(1'b1, 8'h76, 8'h80);
      cd <= 1'b1;
      cyc(6);
      cd <= 1'b0;
      cyc(6);
      chk("det_held", 32'h1, {31'h0, cds});
      bus(1'b1, 8'h78, 8'h80);
      cyc(2);
      chk("det_clr", 32'h0, {31'h0, cds});
      end_of_test();
   end
endmodule
